// ---- port3_pkg.sv ----
// port3_pkg: register offsets, control field positions and reset values
// assumes a 4-bit register port addressed by a small byte-wide address
package port3_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] PIN0_PORT_CONTROL_OFS = 8'h14;
    localparam logic [7:0] PIN1_PORT_CONTROL_OFS = 8'h15;
    localparam logic [7:0] PIN2_PORT_CONTROL_OFS = 8'h16;
    localparam logic [7:0] PIN3_PORT_CONTROL_OFS = 8'h17;
    localparam logic [7:0] PORT_STATUS_OFS       = 8'h18;
    localparam logic [7:0] PULL_CONTROL_OFS      = 8'h19;
    // ************************************************************
    // control field positions and reset values
    // ************************************************************
    localparam int         PIN_IRQ_ENABLE_BIT    = 3;
    localparam int         SAMPLE_CLOCK_SEL_BIT  = 2;
    localparam int         OSC_MONITOR_SEL_BIT   = 2;
    localparam int         PIN_DIRECTION_BIT     = 1;
    localparam int         PIN_DRIVE_SEL_BIT     = 0;
    localparam int         PULL_DIRECTION_BIT    = 0;
    localparam logic [3:0] CONTROL_RESET         = 4'h0;
    localparam logic       PULL_RESET            = 1'b0;
    localparam int         PIN_COUNT             = 4;
    localparam int         MONITOR_PIN           = 3;
endpackage : port3_pkg

// ---- port3_pin_ctrl.sv ----
// port3_pin_ctrl: per-pin pad control and level-change detector
// assumes pin level already synchronised and one-cycle sample strobes
`timescale 1ns/100ps
module port3_pin_ctrl #(
    parameter bit HAS_CLK_SEL = 1'b1                 // pin may choose system clock
) (
    input  wire logic       mclk_i,                  // system clock
    input  wire logic       arst_n_i,                // async reset, active low
    input  wire logic [3:0] ctrl_i,                  // control register value
    input  wire logic       pull_down_i,             // shared pull direction
    input  wire logic       out_data_i,              // port data bit
    input  wire logic       mon_clk_i,               // oscillator monitor clock
    input  wire logic       pin_sync_i,              // synchronised pin level
    input  wire logic       tick_64hz_i,             // time base sample strobe
    input  wire logic       tick_sys_i,              // system clock sample strobe
    output logic            pad_out_o,               // pad output level
    output logic            pad_oe_o,                // pad output enable
    output logic            pull_up_en_o,            // pull-up resistor on
    output logic            pull_dn_en_o,            // pull-down resistor on
    output logic            change_o                 // enabled level change pulse
);
    // ************************************************************
    // pad mode
    // ************************************************************
    logic mon_sel;
    logic out_mode;
    logic drive_sel;
    logic out_val;
    logic sample_tick;
    logic prev_r;
    logic prev_nxt;
    logic change_r;
    logic change_nxt;

    assign mon_sel   = !HAS_CLK_SEL && ctrl_i[port3_pkg::OSC_MONITOR_SEL_BIT];
    assign out_mode  = ctrl_i[port3_pkg::PIN_DIRECTION_BIT] || mon_sel;
    assign drive_sel = ctrl_i[port3_pkg::PIN_DRIVE_SEL_BIT];
    assign out_val   = mon_sel ? mon_clk_i : out_data_i;

    always_comb begin
        pad_out_o    = 1'b0;
        pad_oe_o     = 1'b0;
        pull_up_en_o = 1'b0;
        pull_dn_en_o = 1'b0;
        if (out_mode) begin
            // open drain only pulls low; a high leaves the pin floating
            pad_out_o = drive_sel ? 1'b0 : out_val;
            pad_oe_o  = drive_sel ? !out_val : 1'b1;
        end else if (!drive_sel) begin
            pull_up_en_o = !pull_down_i;
            pull_dn_en_o = pull_down_i;
        end
    end

    // ************************************************************
    // level change detector
    // ************************************************************
    // the fourth pin has no clock choice and always uses the time base
    assign sample_tick = (HAS_CLK_SEL && ctrl_i[port3_pkg::SAMPLE_CLOCK_SEL_BIT])
                         ? tick_sys_i : tick_64hz_i;

    always_comb begin
        prev_nxt   = prev_r;
        change_nxt = 1'b0;
        if (sample_tick) begin
            prev_nxt   = pin_sync_i;
            change_nxt = (pin_sync_i != prev_r) && !out_mode
                         && ctrl_i[port3_pkg::PIN_IRQ_ENABLE_BIT];
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_r   <= 1'b0;
            change_r <= 1'b0;
        end else begin
            prev_r   <= prev_nxt;
            change_r <= change_nxt;
        end
    end

    assign change_o = change_r;

    chk_no_irq_output : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        change_r |-> !$past(out_mode) && $past(ctrl_i[port3_pkg::PIN_IRQ_ENABLE_BIT]))
        else $error("change flagged on output or disabled pin");
    chk_monitor_drive : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (mon_sel && !drive_sel) |-> (pad_oe_o && pad_out_o == mon_clk_i))
        else $error("monitor pin not driven");
endmodule : port3_pin_ctrl

// ---- port3_pin_control_and_level_irq.sv ----
// port3_pin_control_and_level_irq: four-pin port control and level-change interrupt
// assumes a simple strobe register port and a 64 Hz time base tick input
//
// Function
// - control registers are four bits, write-only; no read-modify-write by software
// - bit 3 enables level-change interrupt, only for a pin in input mode
// - bit 2 picks sampling: 0 the 64 Hz tick, 1 the system clock
// - fourth pin always samples with the 64 Hz tick
// - fourth pin bit 2 routes the oscillator monitor clock to the pin
// - monitor select forces the fourth pin to output mode
// - bit 1 sets direction: 0 input, 1 output
// - bit 0: pulled or high-impedance input; push-pull or open-drain output
// - shared pull direction bit: 0 pull-up, 1 pull-down
// - change outputs of all enabled pins ORed into one interrupt request
// - request raised two cycles after the first sampling tick that sees the filtered pin change
`timescale 1ns/100ps
module port3_pin_control_and_level_irq (
    input  wire logic       mclk_i,                  // system clock, 10 MHz
    input  wire logic       arst_n_i,                // async reset, active low
    input  wire logic [7:0] addr_i,                  // register address
    input  wire logic [3:0] wdata_i,                 // write data
    input  wire logic       wr_i,                    // write strobe
    input  wire logic       rd_i,                    // read strobe
    output logic      [3:0] rdata_o,                 // read data, cycle after rd_i
    input  wire logic [3:0] port_data_i,             // port output data bits
    input  wire logic       mon_clk_i,               // oscillator monitor clock
    input  wire logic       tick_64hz_i,             // time base 64 Hz tick
    input  wire logic [3:0] pin_in_i,                // pad input levels
    output logic      [3:0] pin_out_o,               // pad output levels
    output logic      [3:0] pin_oe_o,                // pad output enables
    output logic      [3:0] pull_up_en_o,            // pull-up enables
    output logic      [3:0] pull_dn_en_o,            // pull-down enables
    output logic            ext_level_irq_o          // ORed level-change request
);
    // ************************************************************
    // register file
    // ************************************************************
    logic [3:0] ctrl_r [4];
    logic [3:0] ctrl_nxt [4];
    logic       pull_r;
    logic       pull_nxt;
    logic [3:0] rdata_r;
    logic [3:0] rdata_nxt;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    logic [3:0] level_r;
    logic [3:0] level_nxt;
    logic [3:0] change;
    logic       irq_r;
    logic       irq_nxt;

    // control registers are write-only and read back as zero
    always_comb begin
        for (int i = 0; i < port3_pkg::PIN_COUNT; i++) begin
            ctrl_nxt[i] = ctrl_r[i];
        end
        pull_nxt  = pull_r;
        rdata_nxt = 4'h0;
        if (wr_i) begin
            if (addr_i == port3_pkg::PIN0_PORT_CONTROL_OFS) begin
                ctrl_nxt[0] = wdata_i;
            end else if (addr_i == port3_pkg::PIN1_PORT_CONTROL_OFS) begin
                ctrl_nxt[1] = wdata_i;
            end else if (addr_i == port3_pkg::PIN2_PORT_CONTROL_OFS) begin
                ctrl_nxt[2] = wdata_i;
            end else if (addr_i == port3_pkg::PIN3_PORT_CONTROL_OFS) begin
                ctrl_nxt[3] = wdata_i;
            end else if (addr_i == port3_pkg::PULL_CONTROL_OFS) begin
                pull_nxt = wdata_i[port3_pkg::PULL_DIRECTION_BIT];
            end
        end
        if (rd_i) begin
            if (addr_i == port3_pkg::PORT_STATUS_OFS) begin
                rdata_nxt = level_r;
            end else if (addr_i == port3_pkg::PULL_CONTROL_OFS) begin
                rdata_nxt = {3'h0, pull_r};
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < port3_pkg::PIN_COUNT; i++) begin
                ctrl_r[i] <= port3_pkg::CONTROL_RESET;
            end
            pull_r  <= port3_pkg::PULL_RESET;
            rdata_r <= 4'h0;
        end else begin
            for (int i = 0; i < port3_pkg::PIN_COUNT; i++) begin
                ctrl_r[i] <= ctrl_nxt[i];
            end
            pull_r  <= pull_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;

    // read data stands only in the cycle after its strobe, so idle reads see zero
    chk_read_one_cycle : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !$past(rd_i) |-> rdata_o == 4'h0)
        else $error("read data outside its cycle");
    chk_status_read : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (rd_i && addr_i == port3_pkg::PORT_STATUS_OFS) |=> rdata_o == $past(level_r))
        else $error("status read does not show filtered levels");
    chk_pull_write : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (wr_i && addr_i == port3_pkg::PULL_CONTROL_OFS)
        |=> pull_r == $past(wdata_i[port3_pkg::PULL_DIRECTION_BIT]))
        else $error("pull direction write lost");

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // a change is accepted only when stages two and three agree
    always_comb begin
        level_nxt = level_r;
        for (int i = 0; i < port3_pkg::PIN_COUNT; i++) begin
            if (sync2_r[i] == sync3_r[i]) begin
                level_nxt[i] = sync3_r[i];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            sync3_r <= 4'h0;
            level_r <= 4'h0;
        end else begin
            sync1_r <= pin_in_i;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            level_r <= level_nxt;
        end
    end

    // a glitch shorter than two samples must never reach the detectors
    chk_level_filter : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        ((level_r ^ $past(level_r)) & ($past(sync2_r) ^ $past(sync3_r))) == 4'h0)
        else $error("level accepted before the synchroniser agreed");

    // ************************************************************
    // per-pin control
    // ************************************************************
    // the system clock sample strobe is every cycle of mclk
    for (genvar g = 0; g < port3_pkg::PIN_COUNT; g++) begin : gen_pin
        port3_pin_ctrl #(
            .HAS_CLK_SEL (g != port3_pkg::MONITOR_PIN)
        ) u_pin (
            .mclk_i       (mclk_i),
            .arst_n_i     (arst_n_i),
            .ctrl_i       (ctrl_r[g]),
            .pull_down_i  (pull_r),
            .out_data_i   (port_data_i[g]),
            .mon_clk_i    (mon_clk_i),
            .pin_sync_i   (level_r[g]),
            .tick_64hz_i  (tick_64hz_i),
            .tick_sys_i   (1'b1),
            .pad_out_o    (pin_out_o[g]),
            .pad_oe_o     (pin_oe_o[g]),
            .pull_up_en_o (pull_up_en_o[g]),
            .pull_dn_en_o (pull_dn_en_o[g]),
            .change_o     (change[g])
        );
    end

    // pad modes seen from the top-level pins, checked on pins 1 and 3
    chk_output_no_pull : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        ctrl_r[1][port3_pkg::PIN_DIRECTION_BIT] |-> !(pull_up_en_o[1] || pull_dn_en_o[1]))
        else $error("pull resistor on an output pin");
    chk_cmos_drive : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (ctrl_r[1][1:0] == 2'h2) |-> (pin_oe_o[1] && pin_out_o[1] == port_data_i[1]))
        else $error("push-pull pin not driven");
    chk_open_drain : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (ctrl_r[1][1:0] == 2'h3) |-> (!pin_out_o[1] && pin_oe_o[1] == !port_data_i[1]))
        else $error("open-drain pin drives high");
    chk_monitor_output : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        ctrl_r[3][port3_pkg::OSC_MONITOR_SEL_BIT] |-> !(pull_up_en_o[3] || pull_dn_en_o[3]))
        else $error("monitor pin left as input");

    // ************************************************************
    // shared interrupt request
    // ************************************************************
    // one-cycle pulse; the flag itself lives in the interrupt controller
    assign irq_nxt = |change;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign ext_level_irq_o = irq_r;

    chk_irq_or_changes : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        ext_level_irq_o == |$past(change))
        else $error("interrupt is not the OR of pin changes");
    chk_irq_needs_tick : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $rose(ext_level_irq_o) && ctrl_r[3][3] && !ctrl_r[0][3] && !ctrl_r[1][3]
        && !ctrl_r[2][3] |-> $past(tick_64hz_i, 2))
        else $error("fourth pin change not on a 64 Hz tick");
    // an enable acts two cycles later: one in the pin detector, one in this register
    chk_irq_disabled : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !$past(ctrl_r[0][3], 2) && !$past(ctrl_r[1][3], 2)
        && !$past(ctrl_r[2][3], 2) && !$past(ctrl_r[3][3], 2) |-> !ext_level_irq_o)
        else $error("interrupt raised with every enable clear");
    // register port, then pull select on pin 0 and high-impedance input on pin 1
    chk_ctrl_write : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (wr_i && addr_i == port3_pkg::PIN1_PORT_CONTROL_OFS) |=> ctrl_r[1] == $past(wdata_i))
        else $error("control write lost");
    chk_ctrl_no_read : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (rd_i && addr_i[7:2] == 6'h05) |=> rdata_o == 4'h0)
        else $error("control register read back");
    chk_pull_select : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (ctrl_r[0][1:0] == 2'h0) |-> (pull_dn_en_o[0] == pull_r && pull_up_en_o[0] == !pull_r))
        else $error("pull direction wrong");
    chk_input_hiz : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (ctrl_r[1][1:0] == 2'h1) |-> !(pin_oe_o[1] || pull_up_en_o[1] || pull_dn_en_o[1]))
        else $error("high-impedance input not floating");
endmodule : port3_pin_control_and_level_irq

// ---- pin_board_model.sv ----
// pin_board_model: board circuitry on the far side of the four port pins
// assumes the design raises a pad enable only while it drives that pad
`timescale 1ns/100ps
module pin_board_model (
    input  wire logic       mclk_i,                  // system clock
    input  wire logic [3:0] pin_out_i,               // design pad levels
    input  wire logic [3:0] pin_oe_i,                // design pad enables
    input  wire logic [3:0] pull_up_i,               // design pull-ups
    input  wire logic [3:0] pull_dn_i,               // design pull-downs
    input  wire logic [3:0] ext_en_i,                // board driver on
    input  wire logic [3:0] ext_val_i,               // board driver level
    output logic      [3:0] pin_lvl_o                // resolved pin levels
);
    // ************************************************************
    // pin resolution
    // ************************************************************
    // a floating pin flips every cycle so a stale level is never seen as valid
    logic [3:0] float_r = 4'h0;

    always_ff @(posedge mclk_i) begin
        float_r <= ~pin_lvl_o;
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_oe_i[i]) pin_lvl_o[i] = pin_out_i[i];
            else if (ext_en_i[i]) pin_lvl_o[i] = ext_val_i[i];
            else if (pull_up_i[i]) pin_lvl_o[i] = 1'h1;
            else if (pull_dn_i[i]) pin_lvl_o[i] = 1'h0;
            else pin_lvl_o[i] = float_r[i];
        end
    end
endmodule : pin_board_model

// ---- port3_pin_control_and_level_irq_test.sv ----
// port3_pin_control_and_level_irq_test: self-checking bench for the port control block
// assumes the register port and board model above; single 10 MHz clock
`timescale 1ns/100ps
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module port3_pin_control_and_level_irq_test;
    // ************************************************************
    // signals and instances
    // ************************************************************
    logic       mclk_i = 1'h0;
    logic       arst_n_i = 1'h0;
    logic [7:0] addr_i = 8'h00;
    logic [3:0] wdata_i = 4'h0, port_data_i = 4'h0, ext_en = 4'h0, ext_val = 4'h0;
    logic       wr_i = 1'h0, rd_i = 1'h0, mon_clk_i = 1'h0, tick_64hz_i = 1'h0;
    logic [3:0] rdata_o, pin_in_i, pin_out_o, pin_oe_o, pull_up_en_o, pull_dn_en_o, d;
    logic       ext_level_irq_o;
    int         n_errors = 0, tests_run = 0, c;

    port3_pin_control_and_level_irq port3_pin_control_and_level_irq_inst (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_data_i(port_data_i),
        .mon_clk_i(mon_clk_i), .tick_64hz_i(tick_64hz_i), .pin_in_i(pin_in_i),
        .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pull_up_en_o(pull_up_en_o),
        .pull_dn_en_o(pull_dn_en_o), .ext_level_irq_o(ext_level_irq_o));
    pin_board_model pin_board_model_inst (
        .mclk_i(mclk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
        .pull_up_i(pull_up_en_o), .pull_dn_i(pull_dn_en_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pin_lvl_o(pin_in_i));

    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    // ************************************************************
    // bus and helper tasks
    // ************************************************************
    // whole-value writes only: the control registers cannot be read back
    task automatic wr_reg(input logic [7:0] a, input logic [3:0] v);
        @(posedge mclk_i) begin addr_i <= a; wdata_i <= v; wr_i <= 1'h1; end
        @(posedge mclk_i) wr_i <= 1'h0;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [3:0] v);
        @(posedge mclk_i) begin addr_i <= a; rd_i <= 1'h1; end
        @(posedge mclk_i) rd_i <= 1'h0;
        #1 v = rdata_o;
    endtask : rd_reg
    task automatic tick();
        @(posedge mclk_i) tick_64hz_i <= 1'h1;
        @(posedge mclk_i) tick_64hz_i <= 1'h0;
    endtask : tick
    // two ticks absorb any change flagged against the reset-time sample
    task automatic settle();
        repeat (2) begin repeat (6) @(posedge mclk_i); tick(); end
        repeat (4) @(posedge mclk_i);
    endtask : settle
    task automatic count_irq(input int n, output int k);
        k = 0;
        repeat (n) begin @(negedge mclk_i); if (ext_level_irq_o === 1'h1) k++; end
    endtask : count_irq
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        `CHK(pin_oe_o, 4'h0, "reset oe")
        `CHK(pull_up_en_o, 4'hF, "reset pull-up")
        `CHK(pull_dn_en_o, 4'h0, "reset pull-down")
        rd_reg(port3_pkg::PIN1_PORT_CONTROL_OFS, d);
        `CHK(d, 4'h0, "control read")
        rd_reg(8'h30, d);
        `CHK(d, 4'h0, "unmapped read")
        settle();
        rd_reg(port3_pkg::PORT_STATUS_OFS, d);
        `CHK(d, 4'hF, "pulled levels")
        count_irq(10, c);
        `CHK(c, 0, "irq disabled")
        $display("test reset done");
    endtask : t_reset
    task automatic t_pad();
        @(posedge mclk_i) port_data_i <= 4'h2;
        wr_reg(port3_pkg::PIN1_PORT_CONTROL_OFS, 4'h2);
        `CHK({pin_oe_o[1], pin_out_o[1]}, 2'h3, "cmos drive")
        wr_reg(port3_pkg::PIN1_PORT_CONTROL_OFS, 4'h3);
        `CHK(pin_oe_o[1], 1'h0, "open drain release")
        @(posedge mclk_i) port_data_i <= 4'h0;
        #1 `CHK({pin_oe_o[1], pin_out_o[1]}, 2'h2, "open drain sink")
        wr_reg(port3_pkg::PIN1_PORT_CONTROL_OFS, 4'h1);
        `CHK({pin_oe_o[1], pull_up_en_o[1], pull_dn_en_o[1]}, 3'h0, "hi-z input")
        wr_reg(port3_pkg::PULL_CONTROL_OFS, 4'h1);
        wr_reg(port3_pkg::PIN1_PORT_CONTROL_OFS, 4'h0);
        `CHK({pull_up_en_o[1], pull_dn_en_o[1]}, 2'h1, "pull-down")
        rd_reg(port3_pkg::PULL_CONTROL_OFS, d);
        `CHK(d, 4'h1, "pull readback")
        wr_reg(port3_pkg::PULL_CONTROL_OFS, 4'h0);
        `CHK({pull_up_en_o[1], pull_dn_en_o[1]}, 2'h2, "pull-up")
        $display("test pad done");
    endtask : t_pad
    task automatic t_irq_sys();
        @(posedge mclk_i) begin ext_en <= 4'hF; ext_val <= 4'h0; end
        wr_reg(port3_pkg::PIN0_PORT_CONTROL_OFS, 4'hC);
        settle();
        @(posedge mclk_i) ext_val[0] <= 1'h1;
        count_irq(8, c);
        `CHK(c, 1, "rise sys clock")
        count_irq(12, c);
        `CHK(c, 0, "steady level")
        @(posedge mclk_i) ext_val[0] <= 1'h0;
        count_irq(8, c);
        `CHK(c, 1, "fall sys clock")
        wr_reg(port3_pkg::PIN0_PORT_CONTROL_OFS, 4'hE);
        settle();
        @(posedge mclk_i) port_data_i <= 4'h1;
        count_irq(12, c);
        `CHK(c, 0, "output mode")
        wr_reg(port3_pkg::PIN0_PORT_CONTROL_OFS, 4'h0);
        $display("test irq system clock done");
    endtask : t_irq_sys
    task automatic t_irq_tick();
        wr_reg(port3_pkg::PIN2_PORT_CONTROL_OFS, 4'h8);
        wr_reg(port3_pkg::PIN3_PORT_CONTROL_OFS, 4'h8);
        settle();
        @(posedge mclk_i) ext_val[3:2] <= 2'h3;
        count_irq(12, c);
        `CHK(c, 0, "waits for tick")
        tick();
        count_irq(4, c);
        `CHK(c, 1, "merged request")
        wr_reg(port3_pkg::PIN2_PORT_CONTROL_OFS, 4'h0);
        wr_reg(port3_pkg::PIN3_PORT_CONTROL_OFS, 4'hC);
        `CHK(pin_oe_o[3], 1'h1, "monitor forces output")
        @(posedge mclk_i) mon_clk_i <= 1'h1;
        #1 `CHK(pin_out_o[3], 1'h1, "monitor high")
        @(posedge mclk_i) mon_clk_i <= 1'h0;
        #1 `CHK(pin_out_o[3], 1'h0, "monitor low")
        repeat (12) @(posedge mclk_i);
        tick();
        count_irq(4, c);
        `CHK(c, 0, "monitor no irq")
        wr_reg(port3_pkg::PIN3_PORT_CONTROL_OFS, 4'h8);
        count_irq(12, c);
        `CHK(c, 0, "fourth pin waits for tick")
        tick();
        count_irq(4, c);
        `CHK(c, 1, "fourth pin on tick")
        $display("test irq tick done");
    endtask : t_irq_tick
    // ************************************************************
    // verdict and run control
    // ************************************************************
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results

    initial begin
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'h1;
        #1;
        t_reset();
        t_pad();
        t_irq_sys();
        t_irq_tick();
        results();
    end
    // the run needs well under a thousand cycles
    initial begin
        #(3000 * 100);
        n_errors++;
        results();
    end
endmodule : port3_pin_control_and_level_irq_test
